// File: bench/drive_select_motor_control_test.sv
// self-checking bench joining controller end and drive end over the cable
`timescale 1ns/1ps
module drive_select_motor_control_test;
  localparam int unsigned T_SPIN  = 20;
  localparam int unsigned T_IDLE  = 50;
  localparam int unsigned T_ERASE = 10;
  // clock, reset, bus master
  logic        clock, rst_n, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [3:0]  wb_adr;
  logic [31:0] wb_dat_w, wb_dat_r, q;
  // straps, mechanism and its controls
  logic [3:0]  jumper, mech, oe;
  logic        spindle_on, selected, write_enable, side_one, step_pulse, step_inward, write_flux, jumper_fault;
  int          err_total, checks_done, c;

  dsmc_cable_if cable ();
  assign oe = {cable.read_data_oe, cable.protect_oe, cable.track0_oe, cable.index_oe};
  dsmc_controller #(.SPINUP_CYCLES(T_SPIN), .IDLE_OFF_CYCLES(T_IDLE), .ERASE_CYCLES(T_ERASE)) dsmc_controller_inst
  (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .cable(cable)
  );
  dsmc_drive dsmc_drive_inst
  (
    .clock(clock), .rst_n(rst_n), .cable(cable), .address_jumper_0(jumper[0]), .address_jumper_1(jumper[1]),
    .address_jumper_2(jumper[2]), .address_jumper_3(jumper[3]), .index_pulse(mech[0]), .at_track0(mech[1]),
    .write_protected(mech[2]), .read_flux(mech[3]), .spindle_on(spindle_on), .selected(selected),
    .write_enable(write_enable), .side_one(side_one), .step_pulse(step_pulse), .step_inward(step_inward),
    .write_flux(write_flux), .jumper_fault(jumper_fault)
  );
  dsmc_sva #(.SPINUP_CYCLES(T_SPIN), .ERASE_CYCLES(T_ERASE)) dsmc_sva_inst
  (
    .clock(clock), .rst_n(rst_n), .unit_select_line_n(cable.unit_select_line_n), .motor_on_n(cable.motor_on_n),
    .write_gate_n(cable.write_gate_n), .side_select_n(cable.side_select_n), .step_n(cable.step_n),
    .direction_n(cable.direction_n), .write_data_n(cable.write_data_n), .index_oe(cable.index_oe),
    .track0_oe(cable.track0_oe), .protect_oe(cable.protect_oe), .read_data_oe(cable.read_data_oe)
  );

  // free-running clock
  always #4 clock = ~clock;

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic end_sim;
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic give_up;
    err_total++;
    end_sim();
  endtask : give_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_adr   <= a;
    wb_dat_w <= d;
    do
    begin
      @(posedge clock);
      n++;
      if (n > 20)
        give_up();
    end while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  // bounded wait for a cable event, cycles counted in c
  task automatic wait_hit(input int k, input int lim);
    c = 0;
    while (!((k == 0) ? cable.write_gate_n === 1'b0 : (k == 1) ? cable.unit_select_line_n === 4'hF
      : cable.motor_on_n === 1'b1))
    begin
      @(posedge clock);
      c++;
      if (c > lim)
        give_up();
    end
  endtask : wait_hit

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    wb(1'b1, 4'h8, 32'hFF);
    wb(1'b0, 4'h8, 32'h0);
    check(q, 32'h0);
    wb(1'b0, dsmc_pkg::REG_CONTROL, 32'h0);
    check(q, dsmc_pkg::CONTROL_RESET);
    check(32'({cable.unit_select_line_n, cable.motor_on_n, cable.write_gate_n, cable.side_select_n, oe}),
      32'h7F0);
    check(32'({spindle_on, selected, write_enable, side_one, jumper_fault}), 32'h0);
  endtask : t_reset

  task automatic t_select;
    mech <= 4'hF;
    for (int n = 0; n < 4; n++)
    begin
      jumper <= 4'h1 << n;
      wb(1'b1, dsmc_pkg::REG_CONTROL, 32'h44 | 32'(n));
      repeat (3) @(posedge clock);
      check(32'(cable.unit_select_line_n), {28'h0000000, ~(4'h1 << n)});
      check(32'({selected, side_one, oe}), 32'h3F);
      jumper <= 4'h1 << ((n + 1) % 4);
      repeat (3) @(posedge clock);
      check(32'({selected, side_one, oe}), 32'h10);
    end
    jumper <= 4'h0;
    wb(1'b1, dsmc_pkg::REG_CONTROL, 32'h04);
    repeat (3) @(posedge clock);
    check(32'({jumper_fault, selected}), 32'h3);
    jumper <= 4'h3;
    repeat (3) @(posedge clock);
    check(32'(jumper_fault), 32'h1);
    jumper <= dsmc_pkg::JUMPER_DEFAULT;
    mech   <= 4'h0;
    repeat (3) @(posedge clock);
    check(32'({jumper_fault, selected}), 32'h1);
  endtask : t_select

  task automatic t_write;
    jumper <= 4'h8;
    wb(1'b1, dsmc_pkg::REG_CONTROL, 32'h2F);
    wait_hit(0, T_SPIN + 20);
    check(32'(c >= T_SPIN - 2), 32'h1);
    repeat (2) @(posedge clock);
    check(32'({spindle_on, selected, write_enable}), 32'h7);
    check(32'({step_pulse, step_inward, write_flux}), 32'h0);
    wb(1'b0, dsmc_pkg::REG_STATUS, 32'h0);
    check(q, 32'h7);
    wb(1'b1, dsmc_pkg::REG_CONTROL, 32'h08);
    wb(1'b0, dsmc_pkg::REG_STATUS, 32'h0);
    check(q, 32'hE);
    wait_hit(1, T_ERASE + 20);
    check(32'(c >= T_ERASE - 3), 32'h1);
    repeat (2) @(posedge clock);
    check(32'({selected, write_enable, spindle_on}), 32'h1);
  endtask : t_write

  task automatic t_autooff;
    wb(1'b1, dsmc_pkg::REG_CONTROL, 32'h18);
    wait_hit(2, T_IDLE + 20);
    check(32'(c >= T_IDLE - 5), 32'h1);
    wb(1'b0, dsmc_pkg::REG_STATUS, 32'h0);
    check(32'(q[dsmc_pkg::STS_MOTOR]), 32'h0);
    check(32'(spindle_on), 32'h0);
  endtask : t_autooff

  // reset for four cycles, then the scenarios in turn
  initial
  begin
    clock       = 1'b0;
    rst_n       = 1'b0;
    wb_cyc      = 1'b0;
    wb_stb      = 1'b0;
    wb_we       = 1'b0;
    wb_adr      = 4'h0;
    wb_dat_w    = 32'h0;
    jumper      = 4'h1;
    mech        = 4'h0;
    err_total   = 0;
    checks_done = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_select();
    t_write();
    t_autooff();
    end_sim();
  end
endmodule : drive_select_motor_control_test

// File: bench/dsmc_sva.sv
// checker of the cable between controller end and drive end
`timescale 1ns/1ps
module dsmc_sva
#(
  parameter int unsigned SPINUP_CYCLES = 20,
  parameter int unsigned ERASE_CYCLES  = 10
)
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // controller lines
  input wire logic [3:0] unit_select_line_n,
  input wire logic       motor_on_n,
  input wire logic       write_gate_n,
  input wire logic       side_select_n,
  input wire logic       step_n,
  input wire logic       direction_n,
  input wire logic       write_data_n,
  // drive pull-down enables
  input wire logic       index_oe,
  input wire logic       track0_oe,
  input wire logic       protect_oe,
  input wire logic       read_data_oe
);
  logic [31:0] spin_cnt;
  logic [31:0] erase_cnt;
  logic        gate_q;

  // cycles of motor line low, saturating so it never wraps
  always_ff @(posedge clock)
  begin
    if (!rst_n || motor_on_n)
      spin_cnt <= '0;
    else if (spin_cnt < SPINUP_CYCLES)
      spin_cnt <= spin_cnt + 1;
  end

  // erase window after write gate release, one short so the last edge may move
  always_ff @(posedge clock)
  begin
    gate_q <= write_gate_n;
    if (!rst_n)
      erase_cnt <= '0;
    else if (write_gate_n && !gate_q)
      erase_cnt <= ERASE_CYCLES - 1;
    else if (erase_cnt != 0)
      erase_cnt <= erase_cnt - 1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_select_one_hot: assert property ($onehot0(~unit_select_line_n))
    else $error("more than one unit select asserted");
  a_unused_negated: assert property (step_n && direction_n && write_data_n)
    else $error("unused line not held high");
  a_write_needs_select: assert property (!write_gate_n |-> !(&unit_select_line_n) && !motor_on_n)
    else $error("write gate without select and motor");
  a_spinup_first: assert property ($fell(write_gate_n) |-> spin_cnt >= SPINUP_CYCLES)
    else $error("write gate before spin-up time");
  a_erase_select_hold: assert property (erase_cnt != 0 |-> $stable(unit_select_line_n))
    else $error("select changed inside erase hold");
  a_erase_side_hold: assert property (erase_cnt != 0 |-> $stable(side_select_n))
    else $error("side changed inside erase hold");
  a_gate_off_selected: assert property ($rose(write_gate_n) |-> !(&unit_select_line_n))
    else $error("select dropped with write gate");
  a_idle_released: assert property ((&unit_select_line_n) [*2] |-> !(index_oe || track0_oe || protect_oe
    || read_data_oe))
    else $error("output pulled while no unit selected");
endmodule : dsmc_sva

// File: hw/dsmc_cable_if.sv
// interface of the daisy-chained cable between controller and drive
`timescale 1ns/1ps
interface dsmc_cable_if;
  // active-low lines driven by the controller
  logic [3:0] unit_select_line_n;
  logic       motor_on_n;
  logic       write_gate_n;
  logic       side_select_n;
  logic       step_n;
  logic       direction_n;
  logic       write_data_n;
  // open-collector drive outputs, drive enable high pulls line low
  logic       index_oe;
  logic       track0_oe;
  logic       protect_oe;
  logic       read_data_oe;

  modport controller
  (
    output unit_select_line_n, motor_on_n, write_gate_n, side_select_n, step_n, direction_n, write_data_n,
    input  index_oe, track0_oe, protect_oe, read_data_oe
  );
  modport drive
  (
    input  unit_select_line_n, motor_on_n, write_gate_n, side_select_n, step_n, direction_n, write_data_n,
    output index_oe, track0_oe, protect_oe, read_data_oe
  );
endinterface : dsmc_cable_if

// File: hw/dsmc_controller.sv
// controller end: wishbone registers, unit select, motor timing and erase hold
`timescale 1ns/1ps
module dsmc_controller
#(
  parameter int unsigned SPINUP_CYCLES   = dsmc_pkg::SPINUP_CYCLES,
  parameter int unsigned IDLE_OFF_CYCLES = dsmc_pkg::IDLE_OFF_CYCLES,
  parameter int unsigned ERASE_CYCLES    = dsmc_pkg::ERASE_CYCLES
)
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // cable side
  dsmc_cable_if.controller cable
);
  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  logic [31:0] control;
  logic        req;
  logic        ready;
  logic        erasing;
  logic        write_req;
  logic        idle_expired;
  dsmc_pkg::dsmc_state_t state;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // one wait state answer; unmapped reads return zero, writes dropped
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      control  <= dsmc_pkg::CONTROL_RESET;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && wb_we_i && wb_adr_i == dsmc_pkg::REG_CONTROL && wb_sel_i[0])
        control[7:0] <= {1'b0, wb_dat_i[6:0]};
      else if (idle_expired)
        control[dsmc_pkg::CTL_MOTOR] <= 1'b0;
      if (req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          dsmc_pkg::REG_CONTROL: wb_dat_o <= control;
          dsmc_pkg::REG_STATUS:  wb_dat_o <= {28'h0000000, erasing, ~&cable.unit_select_line_n,
                                              ~cable.motor_on_n, ready};
          default:               wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign write_req = control[dsmc_pkg::CTL_WRITE];

  // ------------------------------------------------------------
  // motor and erase sequencing
  // ------------------------------------------------------------
  logic [dsmc_pkg::TIMER_W-1:0] timer;
  logic [dsmc_pkg::TIMER_W-1:0] idle;
  logic                         motor;

  assign motor = control[dsmc_pkg::CTL_MOTOR];

  // write gate only opens once spun up; erase hold follows a write ended by clearing the write request
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state <= dsmc_pkg::DSMC_IDLE;
      timer <= '0;
    end
    else
    begin
      unique case (state)
        dsmc_pkg::DSMC_IDLE:
        begin
          timer <= '0;
          if (motor)
            state <= dsmc_pkg::DSMC_SPIN;
        end
        dsmc_pkg::DSMC_SPIN:
        begin
          timer <= timer + 1'b1;
          if (!motor)
            state <= dsmc_pkg::DSMC_IDLE;
          else if (timer >= SPINUP_CYCLES[dsmc_pkg::TIMER_W-1:0] - 1'b1)
            state <= dsmc_pkg::DSMC_READY;
        end
        dsmc_pkg::DSMC_READY:
        begin
          timer <= '0;
          if (!write_req && !cable.write_gate_n)
            state <= dsmc_pkg::DSMC_ERASE;
          else if (!motor && cable.write_gate_n)
            state <= dsmc_pkg::DSMC_IDLE;
        end
        dsmc_pkg::DSMC_ERASE:
        begin
          timer <= timer + 1'b1;
          if (timer >= ERASE_CYCLES[dsmc_pkg::TIMER_W-1:0] - 1'b1)
            state <= motor ? dsmc_pkg::DSMC_READY : dsmc_pkg::DSMC_IDLE;
        end
        default:
          state <= dsmc_pkg::DSMC_IDLE;
      endcase
    end
  end

  assign ready   = (state == dsmc_pkg::DSMC_READY);
  assign erasing = (state == dsmc_pkg::DSMC_ERASE);

  // idle counter restarts on any bus access or while writing
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      idle <= '0;
    else if (!motor || req || !cable.write_gate_n || erasing)
      idle <= '0;
    else if (!idle_expired)
      idle <= idle + 1'b1;
  end

  assign idle_expired = control[dsmc_pkg::CTL_AUTO_OFF] && motor &&
                        (idle >= IDLE_OFF_CYCLES[dsmc_pkg::TIMER_W-1:0]);

  // ------------------------------------------------------------
  // cable drivers, all active low
  // ------------------------------------------------------------
  logic [1:0] unit_held;
  logic       side_held;

  // unit and side frozen during write and erase hold
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      unit_held <= 2'h0;
      side_held <= 1'b0;
    end
    else if (cable.write_gate_n && !erasing)
    begin
      unit_held <= control[dsmc_pkg::CTL_UNIT_LSB +: 2];
      side_held <= control[dsmc_pkg::CTL_SIDE];
    end
  end

  // one select line per unit, low selects
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cable.unit_select_line_n <= 4'hF;
      cable.motor_on_n         <= 1'b1;
      cable.write_gate_n       <= 1'b1;
      cable.side_select_n      <= 1'b1;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        cable.unit_select_line_n[i] <= ~((control[dsmc_pkg::CTL_SELECT] || erasing ||
                                         !cable.write_gate_n) && unit_held == i[1:0]);
      cable.motor_on_n    <= ~motor;
      cable.write_gate_n  <= ~(ready && write_req && control[dsmc_pkg::CTL_SELECT]);
      cable.side_select_n <= ~side_held;
    end
  end

  // stepping and data paths are not part of this block, held negated
  assign cable.step_n       = 1'b1;
  assign cable.direction_n  = 1'b1;
  assign cable.write_data_n = 1'b1;
endmodule : dsmc_controller

// File: hw/dsmc_drive.sv
// drive end: address decode, motor enable and gated open-collector outputs
`timescale 1ns/1ps
module dsmc_drive
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // cable side
  dsmc_cable_if.drive     cable,
  // address jumpers, high means shorted
  input  wire logic       address_jumper_0,
  input  wire logic       address_jumper_1,
  input  wire logic       address_jumper_2,
  input  wire logic       address_jumper_3,
  // mechanism status, high means true
  input  wire logic       index_pulse,
  input  wire logic       at_track0,
  input  wire logic       write_protected,
  input  wire logic       read_flux,
  // mechanism controls, high means active
  output logic            spindle_on,
  output logic            selected,
  output logic            write_enable,
  output logic            side_one,
  output logic            step_pulse,
  output logic            step_inward,
  output logic            write_flux,
  output logic            jumper_fault
);
  // ------------------------------------------------------------
  // address capture
  // ------------------------------------------------------------
  logic [3:0] jumpers;
  logic [3:0] address;
  logic [3:0] next_address;

  assign jumpers = {address_jumper_3, address_jumper_2, address_jumper_1, address_jumper_0};

  // only a single shorted jumper is accepted; anything else falls back to unit zero
  always_comb
  begin
    unique case (jumpers)
      4'h1, 4'h2, 4'h4, 4'h8: next_address = jumpers;
      default:                next_address = dsmc_pkg::JUMPER_DEFAULT;
    endcase
  end

  // jumpers are straps, caught each clock so a rework is seen without power cycling
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      address      <= dsmc_pkg::JUMPER_DEFAULT;
      jumper_fault <= 1'b0;
    end
    else
    begin
      address      <= next_address;
      jumper_fault <= (next_address != jumpers);
    end
  end

  // ------------------------------------------------------------
  // select decode and input gating
  // ------------------------------------------------------------
  logic sel_now;

  // low level on the matching line means selected
  assign sel_now = |(address & ~cable.unit_select_line_n);

  // the ten input lines are sampled and decoded active low
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      selected     <= 1'b0;
      spindle_on   <= 1'b0;
      write_enable <= 1'b0;
      side_one     <= 1'b0;
      step_pulse   <= 1'b0;
      step_inward  <= 1'b0;
      write_flux   <= 1'b0;
    end
    else
    begin
      selected     <= sel_now;
      spindle_on   <= ~cable.motor_on_n;
      write_enable <= sel_now & ~cable.write_gate_n;
      side_one     <= sel_now ? ~cable.side_select_n : side_one;
      step_pulse   <= sel_now & cable.write_gate_n & ~cable.step_n; // stepping off during write
      step_inward  <= sel_now ? ~cable.direction_n : step_inward;
      write_flux   <= sel_now & ~cable.write_gate_n & ~cable.write_data_n;
    end
  end

  // ------------------------------------------------------------
  // open-collector outputs
  // ------------------------------------------------------------
  // pulls low only when selected, so other drives own the shared lines otherwise
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cable.index_oe     <= 1'b0;
      cable.track0_oe    <= 1'b0;
      cable.protect_oe   <= 1'b0;
      cable.read_data_oe <= 1'b0;
    end
    else
    begin
      cable.index_oe     <= sel_now & index_pulse;
      cable.track0_oe    <= sel_now & at_track0;
      cable.protect_oe   <= sel_now & write_protected;
      cable.read_data_oe <= sel_now & read_flux & cable.write_gate_n;
    end
  end
endmodule : dsmc_drive

// File: hw/dsmc_pkg.sv
// package of constants shared by the drive end, the controller end and the bench
package dsmc_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLOCK_MHZ        = 125;
  localparam int unsigned SPINUP_MS        = 500;   // one-half second
  localparam int unsigned IDLE_OFF_MS      = 2000;  // two seconds
  localparam int unsigned ERASE_HOLD_MS    = 1;     // tunnel erase hold
  localparam int unsigned CYCLES_PER_MS    = CLOCK_MHZ * 1000;
  localparam int unsigned SPINUP_CYCLES    = SPINUP_MS * CYCLES_PER_MS;
  localparam int unsigned IDLE_OFF_CYCLES  = IDLE_OFF_MS * CYCLES_PER_MS;
  localparam int unsigned ERASE_CYCLES     = ERASE_HOLD_MS * CYCLES_PER_MS;
  localparam int unsigned TIMER_W          = 32;
  // ------------------------------------------------------------
  // cable layout
  // ------------------------------------------------------------
  localparam int unsigned UNITS            = 4;
  localparam int unsigned INPUT_LINES      = 10;
  localparam logic [3:0]  JUMPER_DEFAULT   = 4'h1;  // unit zero shorted
  // ------------------------------------------------------------
  // wishbone register map of the controller end
  // ------------------------------------------------------------
  localparam logic [3:0]  REG_CONTROL      = 4'h0;
  localparam logic [3:0]  REG_STATUS       = 4'h4;
  localparam int unsigned CTL_UNIT_LSB     = 0;   // bits 1:0 unit number
  localparam int unsigned CTL_SELECT       = 2;   // select the unit
  localparam int unsigned CTL_MOTOR        = 3;   // motor request
  localparam int unsigned CTL_AUTO_OFF     = 4;   // idle motor shut-off enable
  localparam int unsigned CTL_WRITE        = 5;   // write gate request
  localparam int unsigned CTL_SIDE         = 6;   // side one
  localparam int unsigned STS_READY        = 0;   // spindle at speed
  localparam int unsigned STS_MOTOR        = 1;   // motor line asserted
  localparam int unsigned STS_SELECTED     = 2;   // a unit select asserted
  localparam int unsigned STS_ERASING      = 3;   // erase hold running
  localparam logic [31:0] CONTROL_RESET    = 32'h0000_0010;

  // controller sequencing states
  typedef enum logic [3:0]
  {
    DSMC_IDLE  = 4'h1,
    DSMC_SPIN  = 4'h2,
    DSMC_READY = 4'h4,
    DSMC_ERASE = 4'h8
  } dsmc_state_t;
endpackage : dsmc_pkg
